/* hw/ifsb_top.sv */
// Purpose: Interrupt flag status bank, groups two and three, APB slave
// Assumes: Request inputs are same-clock logic, high for a request
// Notes:   APB slave with one wait state; unmapped addresses answer pslverr
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_defines.svh"
module ifsb_top
  import ifsb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        capture5_req,
  input  wire logic        capture4_req,
  input  wire logic        capture3_req,
  input  wire logic        can_a_rx_ready_req,
  input  wire logic        serial_port_b_event_req,
  input  wire logic        serial_port_b_error_req,
  input  wire ifsb_flags_t group_two_other_req,
  input  wire logic        dma_channel5_done_req,
  input  wire logic        codec_iface_event_req,
  input  wire logic        codec_iface_error_req,
  input  wire ifsb_flags_t group_three_other_req,
  output var  ifsb_flags_t flag_reg_group_two,
  output var  ifsb_flags_t flag_reg_group_three
);
  ifsb_flags_t g2_set;
  ifsb_flags_t g3_set;
  ifsb_flags_t g2_q;
  ifsb_flags_t g3_q;
  ifsb_sel_t   sel;
  logic        wr_g2;
  logic        wr_g3;
  logic [31:0] prdata_next;
  logic        pslverr_next;
  logic        pready_next;
  ifsb_flags_t g2_out_next;
  ifsb_flags_t g3_out_next;

  // ==========================================================================
  // Address decode
  function automatic ifsb_sel_t decode(input logic [11:0] addr);
    case (addr)
      `IFSB_OFF_GROUP_TWO:   decode = IFSB_SEL_G2;
      `IFSB_OFF_GROUP_THREE: decode = IFSB_SEL_G3;
      default:               decode = IFSB_SEL_NONE;
    endcase
  endfunction : decode

  // A write lands only at the edge where the master samples pready high.
  // Landing it on the first access edge as well would store pwdata twice
  // and wipe a request that arrived in between.
  assign sel   = decode(paddr);
  assign wr_g2 = psel && penable && pready && pwrite && (sel == IFSB_SEL_G2);
  assign wr_g3 = psel && penable && pready && pwrite && (sel == IFSB_SEL_G3);

  // ==========================================================================
  // Request mapping
  always_comb begin
    g2_set = group_two_other_req;
    g2_set[`IFSB_G2_CAPTURE5]    = capture5_req;
    g2_set[`IFSB_G2_CAPTURE4]    = capture4_req;
    g2_set[`IFSB_G2_CAPTURE3]    = capture3_req;
    g2_set[`IFSB_G2_CAN_A_RX]    = can_a_rx_ready_req;
    g2_set[`IFSB_G2_SPORT_B_EVT] = serial_port_b_event_req;
    g2_set[`IFSB_G2_SPORT_B_ERR] = serial_port_b_error_req;
    g3_set = group_three_other_req;
    g3_set[`IFSB_G3_DMA5]      = dma_channel5_done_req;
    g3_set[`IFSB_G3_CODEC_EVT] = codec_iface_event_req;
    g3_set[`IFSB_G3_CODEC_ERR] = codec_iface_error_req;
  end

  ifsb_flag_reg #(
    .IMPL_MASK (`IFSB_G2_IMPL_MASK),
    .RESET_VAL (`IFSB_G2_RESET)
  ) u_group_two (
    .clock    (clock),
    .resetn   (resetn),
    .hw_set   (g2_set),
    .sw_we    (wr_g2),
    .sw_wdata (pwdata[15:0]),
    .flags    (g2_q)
  );

  ifsb_flag_reg #(
    .IMPL_MASK (`IFSB_G3_IMPL_MASK),
    .RESET_VAL (`IFSB_G3_RESET)
  ) u_group_three (
    .clock    (clock),
    .resetn   (resetn),
    .hw_set   (g3_set),
    .sw_we    (wr_g3),
    .sw_wdata (pwdata[15:0]),
    .flags    (g3_q)
  );

  // ==========================================================================
  // APB answer, registered; pready rises on the access phase's first edge
  always_comb begin
    pready_next  = psel && penable && !pready;
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    if (psel && penable && !pready) begin
      case (sel)
        IFSB_SEL_G2: prdata_next = {16'h0000, g2_q};
        IFSB_SEL_G3: prdata_next = {16'h0000, g3_q};
        default:     pslverr_next = 1'b1;
      endcase
    end
    // Outputs lag the flags by one flop to keep every top output registered
    g2_out_next = g2_q;
    g3_out_next = g3_q;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pready               <= 1'b0;
      prdata               <= 32'h0000_0000;
      pslverr              <= 1'b0;
      flag_reg_group_two   <= `IFSB_G2_RESET;
      flag_reg_group_three <= `IFSB_G3_RESET;
    end else begin
      pready               <= pready_next;
      prdata               <= prdata_next;
      pslverr              <= pslverr_next;
      flag_reg_group_two   <= g2_out_next;
      flag_reg_group_three <= g3_out_next;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_capture5_req;
    capture5_req && !wr_g2;
  endsequence
  a_capture5_bit: assert property (@(posedge clock) disable iff (!resetn)
      s_capture5_req |=> ##1 flag_reg_group_two[7])
    else $error("capture five flag not at bit 7");
  a_capture4_bit: assert property (@(posedge clock) disable iff (!resetn)
      capture4_req |=> g2_q[6])
    else $error("capture four flag not at bit 6");
  a_capture3_bit: assert property (@(posedge clock) disable iff (!resetn)
      capture3_req |=> g2_q[5])
    else $error("capture three flag not at bit 5");
  a_can_rx_bit: assert property (@(posedge clock) disable iff (!resetn)
      can_a_rx_ready_req |=> g2_q[2])
    else $error("receive-ready flag not at bit 2");
  a_sport_evt: assert property (@(posedge clock) disable iff (!resetn)
      serial_port_b_event_req |=> g2_q[1])
    else $error("serial event flag not at bit 1");
  a_sport_err: assert property (@(posedge clock) disable iff (!resetn)
      serial_port_b_error_req |=> g2_q[0])
    else $error("serial error flag not at bit 0");
  a_read_value: assert property (@(posedge clock) disable iff (!resetn)
      (psel && penable && !pready && !pwrite && sel == IFSB_SEL_G2)
      |=> (pready && prdata == {16'h0000, $past(g2_q)}))
    else $error("read data differs from flags");
  a_write_zero: assert property (@(posedge clock) disable iff (!resetn)
      (wr_g2 && !pwdata[0] && !serial_port_b_error_req) |=> !g2_q[0])
    else $error("write of zero did not clear flag");
  a_write_one: assert property (@(posedge clock) disable iff (!resetn)
      (wr_g2 && pwdata[7]) |=> g2_q[7])
    else $error("write of one did not set flag");

  // ==========================================================================
  // Group three request positions
  a_dma5_bit: assert property (@(posedge clock) disable iff (!resetn)
      dma_channel5_done_req |=> g3_q[13])
    else $error("transfer-done flag not at bit 13");
  a_codec_evt: assert property (@(posedge clock) disable iff (!resetn)
      codec_iface_event_req |=> g3_q[12])
    else $error("codec event flag not at bit 12");
  a_codec_err: assert property (@(posedge clock) disable iff (!resetn)
      codec_iface_error_req |=> g3_q[11])
    else $error("codec error flag not at bit 11");

  // ==========================================================================
  // Unimplemented bits must never read as one
  a_g2_unimpl: assert property (@(posedge clock) disable iff (!resetn)
      ((g2_q & ~`IFSB_G2_IMPL_MASK) == 16'h0000))
    else $error("unimplemented group two bit set");
  a_g3_unimpl: assert property (@(posedge clock) disable iff (!resetn)
      ((g3_q & ~`IFSB_G3_IMPL_MASK) == 16'h0000))
    else $error("unimplemented group three bit set");

  // ==========================================================================
  // Output copies trail the internal flags by exactly one edge
  a_g2_lag: assert property (@(posedge clock) disable iff (!resetn)
      1'b1 |=> (flag_reg_group_two == $past(g2_q)))
    else $error("group two output copy out of step");
  a_g3_lag: assert property (@(posedge clock) disable iff (!resetn)
      1'b1 |=> (flag_reg_group_three == $past(g3_q)))
    else $error("group three output copy out of step");

  // ==========================================================================
  // Bus answer shape
  sequence s_access_first;
    psel && penable && !pready;
  endsequence
  sequence s_read_g3;
    s_access_first ##0 (!pwrite && sel == IFSB_SEL_G3);
  endsequence
  a_ready_pulse: assert property (@(posedge clock) disable iff (!resetn)
      pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_access_ready: assert property (@(posedge clock) disable iff (!resetn)
      s_access_first |=> pready)
    else $error("access not answered after one wait state");
  a_err_with_ready: assert property (@(posedge clock) disable iff (!resetn)
      pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (@(posedge clock) disable iff (!resetn)
      !pready |-> (prdata == 32'h0000_0000))
    else $error("read data not zero outside answer");
  a_unmapped_err: assert property (@(posedge clock) disable iff (!resetn)
      (s_access_first ##0 (sel == IFSB_SEL_NONE)) |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (@(posedge clock) disable iff (!resetn)
      (s_access_first ##0 (sel != IFSB_SEL_NONE)) |=> !pslverr)
    else $error("mapped access refused");
  a_read_g3: assert property (@(posedge clock) disable iff (!resetn)
      s_read_g3 |=> (pready && prdata == {16'h0000, $past(g3_q)}))
    else $error("group three read data differs from flags");
  a_write_g3: assert property (@(posedge clock) disable iff (!resetn)
      (wr_g3 && g3_set == 16'h0000)
      |=> (g3_q == ($past(pwdata[15:0]) & `IFSB_G3_IMPL_MASK)))
    else $error("group three write not stored");
  // A refused write must leave both registers alone when no request races it
  a_unmapped_keep: assert property (@(posedge clock) disable iff (!resetn)
      (psel && penable && pready && pwrite && sel == IFSB_SEL_NONE
       && g2_set == 16'h0000 && g3_set == 16'h0000)
      |=> (g2_q == $past(g2_q) && g3_q == $past(g3_q)))
    else $error("unmapped write changed a flag register");
endmodule : ifsb_top
`default_nettype wire

/* hw/ifsb_defines.svh */
// Purpose: Offsets, field positions and reset values of the flag status bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Flag registers are 16 bits wide, upper bus bits read as zero
`ifndef IFSB_DEFINES_SVH
`define IFSB_DEFINES_SVH

// ==========================================================================
// Register map
`define IFSB_OFF_GROUP_TWO    12'h000
`define IFSB_OFF_GROUP_THREE  12'h004
`define IFSB_ADDR_W           12

// ==========================================================================
// Group two fields
`define IFSB_G2_CAPTURE5      7
`define IFSB_G2_CAPTURE4      6
`define IFSB_G2_CAPTURE3      5
`define IFSB_G2_CAN_A_RX      2
`define IFSB_G2_SPORT_B_EVT   1
`define IFSB_G2_SPORT_B_ERR   0
`define IFSB_G2_IMPL_MASK     16'h00E7

// ==========================================================================
// Group three fields
`define IFSB_G3_DMA5          13
`define IFSB_G3_CODEC_EVT     12
`define IFSB_G3_CODEC_ERR     11
`define IFSB_G3_IMPL_MASK     16'h39FF

// ==========================================================================
// Reset values
`define IFSB_G2_RESET         16'h0000
`define IFSB_G3_RESET         16'h0000

`endif

/* hw/ifsb_pkg.sv */
// Purpose: Types shared by the flag status bank
// Assumes: Nothing beyond the defines header
// Notes:   Constants live in the header as macros
package ifsb_pkg;
  typedef logic [15:0] ifsb_flags_t;
  typedef enum logic [1:0] {
    IFSB_SEL_NONE,
    IFSB_SEL_G2,
    IFSB_SEL_G3
  } ifsb_sel_t;
endpackage : ifsb_pkg

/* hw/ifsb_flag_reg.sv */
// Purpose: One 16-bit sticky flag register with software write
// Assumes: Requests are single-clock-domain logic pulses or levels
// Notes:   Hardware set wins over a software clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ifsb_flag_reg
  import ifsb_pkg::*;
#(
  parameter ifsb_flags_t IMPL_MASK = 16'hFFFF,
  parameter ifsb_flags_t RESET_VAL = 16'h0000
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire ifsb_flags_t hw_set,
  input  wire logic        sw_we,
  input  wire ifsb_flags_t sw_wdata,
  output var  ifsb_flags_t flags
);
  ifsb_flags_t flags_reg;
  ifsb_flags_t flags_next;

  // ==========================================================================
  // Next state
  always_comb begin
    flags_next = flags_reg;
    if (sw_we) begin
      flags_next = sw_wdata;
    end
    flags_next = (flags_next | hw_set) & IMPL_MASK;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      flags_reg <= RESET_VAL;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

  a_set_sticks: assert property (@(posedge clock) disable iff (!resetn)
      (!sw_we ##0 (flags_reg != 16'h0000)) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("flag cleared without software write");
  a_set_wins: assert property (@(posedge clock) disable iff (!resetn)
      (hw_set != 16'h0000) |=> ((flags_reg & $past(hw_set) & IMPL_MASK) == ($past(hw_set) & IMPL_MASK)))
    else $error("hardware request lost");
  a_sw_write: assert property (@(posedge clock) disable iff (!resetn)
      (sw_we && hw_set == 16'h0000) |=> (flags_reg == ($past(sw_wdata) & IMPL_MASK)))
    else $error("software write not stored");
endmodule : ifsb_flag_reg
`default_nettype wire

/* bench/ifsb_req_src.sv */
// Purpose: Peripheral request sources facing the flag status bank
// Assumes: Requests are one-clock pulses, active high
// Notes:   Pulses, not levels, so only stickiness can keep a flag up
`timescale 1ns/1ps
`default_nettype none
module ifsb_req_src (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [8:0] fire,
  output var  logic [8:0] req
);
  // ==========================================================
  // Request pulses
  always_ff @(posedge clock) begin
    if (!resetn)
      req <= 9'h000;
    else
      req <= fire;
  end
endmodule : ifsb_req_src
`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench for the flag status bank
// Assumes: One wait state per APB access, flags one cycle after a request
// Notes:   Hardware-over-software priority in one cycle is not exercised
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_defines.svh"
module tb;
  import ifsb_pkg::*;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [8:0]  fire, req;
  ifsb_flags_t fg2, fg3;
  int          fails = 0, n_tests = 0, cyc = 0, e2 = 0, e3 = 0;
  int          bp[9] = '{0, 1, 2, 5, 6, 7, 11, 12, 13};
  ifsb_top ifsb_top_i (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture5_req(req[5]), .capture4_req(req[4]),
    .capture3_req(req[3]), .can_a_rx_ready_req(req[2]), .serial_port_b_event_req(req[1]),
    .serial_port_b_error_req(req[0]), .group_two_other_req(16'h0000),
    .dma_channel5_done_req(req[8]), .codec_iface_event_req(req[7]),
    .codec_iface_error_req(req[6]), .group_three_other_req(16'h0000),
    .flag_reg_group_two(fg2), .flag_reg_group_three(fg3));
  ifsb_req_src ifsb_req_src_i (.clock(clock), .resetn(resetn), .fire(fire), .req(req));
  // ==========================================================
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  // ==========================================================
  // Tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Holds the request until pready, then idles one cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rd, e);
  endtask : rdchk
  task summarize;
    $display("n_tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    fire = 9'h000;
    void'($urandom(75));
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rdchk(`IFSB_OFF_GROUP_TWO, 32'h00000000);
    rdchk(`IFSB_OFF_GROUP_THREE, 32'h00000000);
    // Flags accumulate: earlier pulses must still read back
    for (int i = 0; i < 9; i++) begin
      fire <= 9'(1 << i);
      @(posedge clock);
      fire <= 9'h000;
      repeat (3) @(posedge clock);
      if (i < 6) e2 |= 1 << bp[i];
      else e3 |= 1 << bp[i];
      rdchk(`IFSB_OFF_GROUP_TWO, 32'(e2));
      rdchk(`IFSB_OFF_GROUP_THREE, 32'(e3));
      chk({16'h0000, fg2}, 32'(e2));
    end
    apb(1'b1, `IFSB_OFF_GROUP_TWO, 32'h00000000);
    rdchk(`IFSB_OFF_GROUP_TWO, 32'h00000000);
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      apb(1'b1, `IFSB_OFF_GROUP_TWO, v);
      e2 = v[15:0] & `IFSB_G2_IMPL_MASK;
      rdchk(`IFSB_OFF_GROUP_TWO, 32'(e2));
      chk({16'h0000, fg2}, 32'(e2));
      apb(1'b1, `IFSB_OFF_GROUP_THREE, ~v);
      e3 = ~v[15:0] & `IFSB_G3_IMPL_MASK;
      rdchk(`IFSB_OFF_GROUP_THREE, 32'(e3));
      chk({31'h0, er}, 32'h00000000);
    end
    apb(1'b1, 12'h008, 32'h00000000);
    chk({31'h0, er}, 32'h00000001);
    rdchk(`IFSB_OFF_GROUP_TWO, 32'(e2));
    summarize();
  end
endmodule : tb
`default_nettype wire
